// ===== rtl/adc_demux_regs.svh
// Constants for the converter output demux and its capture end
`ifndef ADC_DEMUX_REGS_SVH
`define ADC_DEMUX_REGS_SVH

`define SAMPLE_WIDTH 8
`define UPPER_BITS 5
`define LSB_BITS 3
`define LATENCY_HALF_CYCLES 7
`define PIPE_STAGES ((`LATENCY_HALF_CYCLES + 1) / 2 - 1)
`define FULL_SCALE_CODE 8'hff
`define ZERO_SCALE_CODE 8'h00
`define SINGLE_MAX_MSPS 125
`define CLK_MHZ 20
`define REFILL_CYCLES 8
`define REFILL_WIDTH 4
`define BUFFER_DEPTH 2

`endif

// ===== rtl/adc_demux_pkg.sv
// Types shared by the converter end and the capture end
`include "adc_demux_regs.svh"

package adc_demux_pkg;

    typedef enum logic [1:0] {
        MODE_PARALLEL = 2'b00,
        MODE_INTERLEAVED = 2'b01,
        MODE_SINGLE = 2'b10
    } mode_type;

    typedef struct packed {
        logic [1:0] sync_mode_first;
        logic [1:0] sync_mode_second;
        logic [1:0] sync_sleep;
        logic [1:0] sync_align_p;
        logic [1:0] sync_align_n;
        logic align_seen;
        logic [`UPPER_BITS-1:0] upper_hold;
        logic upper_valid;
        logic [`PIPE_STAGES-1:0][`SAMPLE_WIDTH-1:0] pipe;
        logic [`PIPE_STAGES-1:0] pipe_valid;
        logic phase;
        logic [`SAMPLE_WIDTH-1:0] a_hold;
        logic [`SAMPLE_WIDTH-1:0] bank_a;
        logic [`SAMPLE_WIDTH-1:0] bank_b;
        logic strobe;
        logic drive;
    } conv_state_type;

    typedef struct packed {
        logic [1:0][`SAMPLE_WIDTH-1:0] sync_a;
        logic [1:0][`SAMPLE_WIDTH-1:0] sync_b;
        logic [1:0] sync_strobe;
        logic [1:0] sync_drive;
        logic strobe_seen;
        logic [1:0] mode_drv;
        logic sleep_drv;
        logic align_drv;
        logic [`REFILL_WIDTH-1:0] refill;
        logic [`BUFFER_DEPTH-1:0][2*`SAMPLE_WIDTH+1:0] slots;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } cap_state_type;

endpackage

// ===== rtl/adc_link_if.sv
// Pin-level link between the converter output end and the capture end
`timescale 1ns/1ps
`default_nettype none
`include "adc_demux_regs.svh"

interface adc_link_if;
    logic mode_select_first;
    logic mode_select_second;
    logic sleep_request_pin;
    logic align_reset_p;
    logic align_reset_n;
    logic [`SAMPLE_WIDTH-1:0] bank_a_sample_o;
    logic [`SAMPLE_WIDTH-1:0] bank_b_sample_o;
    logic output_data_strobe_o;
    logic output_data_strobe_n_o;
    logic outputs_oe;
    logic [`SAMPLE_WIDTH-1:0] bank_a_sample;
    logic [`SAMPLE_WIDTH-1:0] bank_b_sample;
    logic output_data_strobe;
    logic output_data_strobe_n;

    // Released pins settle low here
    assign bank_a_sample = outputs_oe ? bank_a_sample_o : '0;
    assign bank_b_sample = outputs_oe ? bank_b_sample_o : '0;
    assign output_data_strobe = outputs_oe & output_data_strobe_o;
    assign output_data_strobe_n = outputs_oe & output_data_strobe_n_o;

    modport converter (
        input mode_select_first,
        input mode_select_second,
        input sleep_request_pin,
        input align_reset_p,
        input align_reset_n,
        output bank_a_sample_o,
        output bank_b_sample_o,
        output output_data_strobe_o,
        output output_data_strobe_n_o,
        output outputs_oe
    );

    modport capture (
        output mode_select_first,
        output mode_select_second,
        output sleep_request_pin,
        output align_reset_p,
        output align_reset_n,
        input bank_a_sample,
        input bank_b_sample,
        input output_data_strobe,
        input output_data_strobe_n,
        input outputs_oe
    );
endinterface

`default_nettype wire

// ===== rtl/converter_end.sv
// Converter output end: latency pipeline, bank selection and output modes
//
// Functional notes
// - Sample reaches bank selection after 3.5 cycles
// - LSBs latched one cycle after MSBs
// - Both mode pins low: parallel dual output
// - First low, second high: interleaved dual
// - First high: single bank A, second ignored
// - Single mode: every sample on bank A
// - Interleaved: alternate banks each cycle
// - Parallel: bank A delayed, both update together
// - Divided clock phase selects the bank
// - Align reset restarts bank selection at A
// - Alignment only in dual modes
// - Strobe: latch strobe or bank indicator
// - Straight binary eight bit coding
// - Sleep pin releases all outputs
`timescale 1ns/1ps
`default_nettype none
`include "adc_demux_regs.svh"

module converter_end (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [`UPPER_BITS-1:0] sample_upper,
    input wire logic [`LSB_BITS-1:0] sample_lsb,
    input wire logic sample_valid,
    adc_link_if.converter link
);
    import adc_demux_pkg::*;

    conv_state_type r;
    conv_state_type next_r;
    mode_type mode;
    logic sleeping;
    logic align_level;
    logic align_rise;
    logic [`SAMPLE_WIDTH-1:0] head;
    logic head_valid;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.sync_mode_first = {r.sync_mode_first[0],
                                  link.mode_select_first};
        next_r.sync_mode_second = {r.sync_mode_second[0],
                                   link.mode_select_second};
        next_r.sync_sleep = {r.sync_sleep[0], link.sleep_request_pin};
        next_r.sync_align_p = {r.sync_align_p[0], link.align_reset_p};
        next_r.sync_align_n = {r.sync_align_n[0], link.align_reset_n};

        if (r.sync_mode_first[1]) begin
            mode = MODE_SINGLE;
        end else if (r.sync_mode_second[1]) begin
            mode = MODE_INTERLEAVED;
        end else begin
            mode = MODE_PARALLEL;
        end

        sleeping = r.sync_sleep[1];
        align_level = r.sync_align_p[1] & ~r.sync_align_n[1];
        align_rise = align_level & ~r.align_seen;
        next_r.align_seen = align_level;

        // hold upper bits until LSBs arrive
        next_r.upper_hold = sample_upper;
        next_r.upper_valid = sample_valid & ~sleeping;

        next_r.pipe[0] = {r.upper_hold, sample_lsb};
        next_r.pipe_valid[0] = r.upper_valid;

        for (int i = 1; i < `PIPE_STAGES; i++) begin
            next_r.pipe[i] = r.pipe[i-1];
            next_r.pipe_valid[i] = r.pipe_valid[i-1];
        end
        head = r.pipe[`PIPE_STAGES-1];
        head_valid = r.pipe_valid[`PIPE_STAGES-1];

        next_r.phase = ~r.phase;
        if (align_rise && mode != MODE_SINGLE) begin
            next_r.phase = 1'b0;
        end

        case (mode)
            MODE_SINGLE: begin
                if (head_valid) begin
                    next_r.bank_a = head;
                    next_r.strobe = ~r.strobe;
                end
            end
            MODE_INTERLEAVED: begin
                if (head_valid) begin
                    if (!r.phase) begin
                        next_r.bank_a = head;
                        next_r.strobe = 1'b1;
                    end else begin
                        next_r.bank_b = head;
                        next_r.strobe = 1'b0;
                    end
                end
            end
            MODE_PARALLEL: begin
                // delay bank A to meet bank B
                next_r.strobe = 1'b0;
                if (!r.phase) begin
                    next_r.a_hold = head;
                end else if (head_valid) begin
                    next_r.bank_a = r.a_hold;
                    next_r.bank_b = head;
                    next_r.strobe = 1'b1;
                end
            end
            default: begin
                next_r.strobe = r.strobe;
            end
        endcase

        next_r.drive = ~sleeping;
        if (sleeping) begin
            next_r.pipe_valid = '0;
            next_r.upper_valid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    assign link.bank_a_sample_o = r.bank_a;
    assign link.bank_b_sample_o = r.bank_b;
    assign link.output_data_strobe_o = r.strobe;
    assign link.output_data_strobe_n_o = ~r.strobe;
    assign link.outputs_oe = r.drive;

endmodule

`default_nettype wire

// ===== rtl/capture_end.sv
// Capture end: drives mode, sleep and align pins, buffers received words
`timescale 1ns/1ps
`default_nettype none
`include "adc_demux_regs.svh"

module capture_end (
    input wire logic clk,
    input wire logic arst_n,
    input wire adc_demux_pkg::mode_type mode_cfg,
    input wire logic sleep_cmd,
    input wire logic align_cmd,
    output logic [2*`SAMPLE_WIDTH-1:0] word_data,
    output logic word_pair,
    output logic word_bank_b,
    output logic word_valid,
    input wire logic word_ready,
    output logic capture_ready,
    adc_link_if.capture link
);
    import adc_demux_pkg::*;

    cap_state_type r;
    cap_state_type next_r;
    mode_type mode_now;
    logic strobe_lvl;
    logic event_new;
    logic push;
    logic pop;
    logic [2*`SAMPLE_WIDTH+1:0] entry;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        // first pin high is single, second ignored
        mode_now = r.mode_drv[1] ? MODE_SINGLE : mode_type'(r.mode_drv);
        next_r.sync_a = {r.sync_a[0], link.bank_a_sample};
        next_r.sync_b = {r.sync_b[0], link.bank_b_sample};
        next_r.sync_strobe = {r.sync_strobe[0],
                              link.output_data_strobe &
                              ~link.output_data_strobe_n};
        next_r.sync_drive = {r.sync_drive[0], link.outputs_oe};
        strobe_lvl = r.sync_strobe[1];
        next_r.strobe_seen = strobe_lvl;

        next_r.mode_drv = mode_cfg;
        next_r.sleep_drv = sleep_cmd;
        next_r.align_drv = align_cmd;

        if (r.refill != '0) begin
            next_r.refill = r.refill - 1'b1;
        end
        if (2'(mode_cfg) != r.mode_drv || (r.sleep_drv && !sleep_cmd)
            || align_cmd) begin
            next_r.refill = `REFILL_WIDTH'(`REFILL_CYCLES);
        end

        // single mode: each strobe change is a word
        case (mode_now)
            MODE_PARALLEL: begin
                event_new = strobe_lvl & ~r.strobe_seen;
            end
            MODE_INTERLEAVED, MODE_SINGLE: begin
                event_new = strobe_lvl ^ r.strobe_seen;
            end
            default: begin
                event_new = 1'b0;
            end
        endcase

        entry = {r.sync_b[1], r.sync_a[1],
                 mode_now == MODE_PARALLEL,
                 mode_now == MODE_INTERLEAVED && !strobe_lvl};
        if (mode_now == MODE_INTERLEAVED && !strobe_lvl) begin
            entry[2*`SAMPLE_WIDTH+1:2] = {r.sync_b[1], r.sync_b[1]};
        end

        push = event_new & r.sync_drive[1] & (r.refill == '0)
               & (r.count != 2'(`BUFFER_DEPTH));
        pop = (r.count != 2'd0) & word_ready;

        if (push) begin
            next_r.slots[r.wr_ptr] = entry;
            next_r.wr_ptr = ~r.wr_ptr;
        end
        if (pop) begin
            next_r.rd_ptr = ~r.rd_ptr;
        end
        next_r.count = r.count + 2'(push) - 2'(pop);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.mode_select_first = r.mode_drv[1];
    assign link.mode_select_second = r.mode_drv[0];
    assign link.sleep_request_pin = r.sleep_drv;
    assign link.align_reset_p = r.align_drv;
    assign link.align_reset_n = ~r.align_drv;
    assign word_data = r.slots[r.rd_ptr][2*`SAMPLE_WIDTH+1:2];
    assign word_pair = r.slots[r.rd_ptr][1];
    assign word_bank_b = r.slots[r.rd_ptr][0];
    assign word_valid = r.count != 2'd0;
    assign capture_ready = r.count != 2'(`BUFFER_DEPTH);

endmodule

`default_nettype wire

// ===== bench/adc_link_assertions.sv
// Assertions on the converter-to-capture link
`timescale 1ns/1ps
`default_nettype none
`include "adc_demux_regs.svh"

module adc_link_assertions (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic mode_select_first,
    input wire logic mode_select_second,
    input wire logic sleep_request_pin,
    input wire logic [`SAMPLE_WIDTH-1:0] bank_a_sample_o,
    input wire logic [`SAMPLE_WIDTH-1:0] bank_b_sample_o,
    input wire logic output_data_strobe_o,
    input wire logic output_data_strobe_n_o,
    input wire logic outputs_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ------------------------
    // Settled mode windows
    // ------------------------
    sequence s_single;
        (mode_select_first && outputs_oe) [*5];
    endsequence
    sequence s_inter;
        (!mode_select_first && mode_select_second && outputs_oe) [*5];
    endsequence
    sequence s_par;
        (!mode_select_first && !mode_select_second && outputs_oe) [*5];
    endsequence

    AST_SLEEP_OFF: assert property (sleep_request_pin [*4] |-> !outputs_oe)
        else $error("outputs still driven in sleep");
    AST_STROBE_PAIR: assert property (outputs_oe |->
        output_data_strobe_n_o == !output_data_strobe_o)
        else $error("strobe pair not complementary");
    AST_SINGLE_NO_B: assert property (s_single |-> $stable(bank_b_sample_o))
        else $error("bank b written in single mode");
    AST_SINGLE_TOGGLE: assert property (s_single ##0 $changed(bank_a_sample_o)
        |-> $changed(output_data_strobe_o))
        else $error("no strobe toggle with new sample");
    AST_INTER_B: assert property (s_inter ##0 $changed(bank_b_sample_o)
        |-> !output_data_strobe_o && $stable(bank_a_sample_o))
        else $error("bank b update not alone or strobe high");
    AST_INTER_A: assert property (s_inter ##0 $changed(bank_a_sample_o)
        |-> output_data_strobe_o)
        else $error("bank a update without strobe high");
    AST_PAR_TOGETHER: assert property (s_par ##0 ($changed(bank_a_sample_o)
        || $changed(bank_b_sample_o)) |-> output_data_strobe_o)
        else $error("parallel update without strobe");
    AST_PAR_PULSE: assert property (s_par ##0 output_data_strobe_o
        |=> !output_data_strobe_o)
        else $error("parallel strobe longer than one cycle");
endmodule

`default_nettype wire

// ===== bench/adc_output_demux_control_tb_top.sv
// Testbench joining converter end and capture end over the link
`timescale 1ns/1ps
`default_nettype none

module adc_output_demux_control_tb_top;
    import adc_demux_pkg::*;
    logic clk;
    logic arst_n;
    logic [4:0] sample_upper;
    logic [2:0] sample_lsb;
    logic sample_valid;
    mode_type mode_cfg;
    logic sleep_cmd;
    logic align_cmd;
    logic [15:0] word_data;
    logic word_pair;
    logic word_bank_b;
    logic word_valid;
    logic word_ready;
    logic capture_ready;
    int n_fail;
    int check_count;
    int cycles;
    int nwords;
    bit chk_on;
    bit have_prev;
    logic [7:0] prev;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] v;
    logic [2:0] lsb_prev;
    logic [7:0] codes [4] = '{8'hff, 8'h00, 8'hff, 8'h00};

    adc_link_if lk ();
    converter_end converter_end_inst (.clk(clk), .arst_n(arst_n),
        .sample_upper(sample_upper), .sample_lsb(sample_lsb),
        .sample_valid(sample_valid), .link(lk));
    capture_end capture_end_inst (.clk(clk), .arst_n(arst_n),
        .mode_cfg(mode_cfg), .sleep_cmd(sleep_cmd), .align_cmd(align_cmd),
        .word_data(word_data), .word_pair(word_pair),
        .word_bank_b(word_bank_b), .word_valid(word_valid),
        .word_ready(word_ready), .capture_ready(capture_ready), .link(lk));
    adc_link_assertions adc_link_assertions_inst (.clk(clk),
        .arst_n(arst_n), .mode_select_first(lk.mode_select_first),
        .mode_select_second(lk.mode_select_second),
        .sleep_request_pin(lk.sleep_request_pin),
        .bank_a_sample_o(lk.bank_a_sample_o),
        .bank_b_sample_o(lk.bank_b_sample_o),
        .output_data_strobe_o(lk.output_data_strobe_o),
        .output_data_strobe_n_o(lk.output_data_strobe_n_o),
        .outputs_oe(lk.outputs_oe));

    // ------------------------
    // Shared tasks
    // ------------------------
    task automatic chk(input string nm, input logic [7:0] exp,
        input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Counting samples, upper now and low bits one cycle later
    task automatic run_stream(input int n);
        repeat (n) begin
            @(posedge clk);
            sample_upper <= v[7:3];
            sample_lsb <= lsb_prev;
            sample_valid <= 1'b1;
            lsb_prev = v[2:0];
            v = v + 8'h01;
        end
    endtask

    task automatic stop_stream();
        @(posedge clk);
        sample_lsb <= lsb_prev;
        sample_valid <= 1'b0;
    endtask

    task automatic phase(input mode_type m, input logic al);
        mode_cfg <= m;
        chk_on = 1'b0;
        run_stream(10);
        align_cmd <= al;
        run_stream(4);
        align_cmd <= 1'b0;
        run_stream(20);
        nwords = 0;
        chk_on = 1'b1;
        run_stream(60);
        chk_on = 1'b0;
        chk("words", 8'h01, {7'h00, nwords >= 20});
    endtask

    // One isolated sample, cycles counted until bank a shows it
    task automatic send_one(input logic [7:0] val);
        logic [7:0] old;
        int k;
        old = lk.bank_a_sample_o;
        k = 0;
        @(posedge clk);
        sample_upper <= val[7:3];
        sample_lsb <= val[2:0];
        sample_valid <= 1'b1;
        repeat (10) begin
            @(negedge clk);
            if (lk.bank_a_sample_o === old) k++;
            @(posedge clk);
            sample_valid <= 1'b0;
        end
        if (old !== val) chk("latency", 8'h05, k[7:0]);
        chk("code", val, lk.bank_a_sample);
    endtask

    // ------------------------
    // Word monitor
    // ------------------------
    always @(negedge clk) begin
        if (!chk_on) begin
            have_prev = 1'b0;
        end else if (word_valid === 1'b1 && word_ready === 1'b1) begin
            nwords++;
            lo = word_data[7:0];
            hi = word_data[15:8];
            if (lk.mode_select_first === 1'b1) begin
                hi = lo;
            end else if (lk.mode_select_second === 1'b1) begin
                if (word_bank_b) lo = hi;
                else hi = lo;
            end else begin
                chk("pair", 8'h01, {7'h00, word_pair});
                chk("bank_b", lo + 8'h01, hi);
            end
            if (have_prev) chk("next", prev + 8'h01, lo);
            prev = hi;
            have_prev = 1'b1;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------
    // Main sequence
    // ------------------------
    initial begin
        arst_n = 1'b0;
        sample_upper = 5'h00;
        sample_lsb = 3'h0;
        sample_valid = 1'b0;
        mode_cfg = MODE_SINGLE;
        sleep_cmd = 1'b0;
        align_cmd = 1'b0;
        word_ready = 1'b1;
        v = 8'h00;
        lsb_prev = 3'h0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        phase(MODE_SINGLE, 1'b0);
        phase(MODE_INTERLEAVED, 1'b1);
        phase(MODE_PARALLEL, 1'b1);
        phase(mode_type'(2'b11), 1'b0);
        sleep_cmd <= 1'b1;
        run_stream(12);
        @(negedge clk);
        chk("oe", 8'h00, {7'h00, lk.outputs_oe});
        chk("bank_a", 8'h00, lk.bank_a_sample);
        chk("strobe", 8'h00, {7'h00, lk.output_data_strobe});
        chk("drained", 8'h00, {7'h00, word_valid});
        sleep_cmd <= 1'b0;
        phase(MODE_SINGLE, 1'b0);
        word_ready <= 1'b0;
        run_stream(12);
        @(negedge clk);
        chk("full", 8'h00, {7'h00, capture_ready});
        chk("held", 8'h01, {7'h00, word_valid});
        run_stream(2);
        word_ready <= 1'b1;
        stop_stream();
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk("empty", 8'h00, {7'h00, word_valid});
        foreach (codes[i]) send_one(codes[i]);
        summarize();
    end
endmodule

`default_nettype wire
